// ---- shared/pirc_defs.svh ----
// offsets, bit positions and reset values of the management registers
`ifndef PIRC_DEFS_SVH
`define PIRC_DEFS_SVH
`define PIRC_ADDR_EVENT      5'h1b
`define PIRC_ADDR_DIAG       5'h1d
`define PIRC_ADDR_MISC       5'h1e
`define PIRC_ADDR_XOVER      5'h1f
`define PIRC_EV_ENA_HI       15
`define PIRC_EV_ENA_LO       8
`define PIRC_EV_STAT_HI      7
`define PIRC_EV_STAT_LO      0
`define PIRC_EV_WIDTH        8
`define PIRC_EV_RESET        8'h00
`define PIRC_DIAG_START_BIT  15
`define PIRC_DIAG_RES_HI     14
`define PIRC_DIAG_RES_LO     13
`define PIRC_DIAG_CNT_HI     8
`define PIRC_DIAG_CNT_LO     0
`define PIRC_DIAG_RES_RESET  2'h0
`define PIRC_DIAG_CNT_RESET  9'h000
`define PIRC_IND_MODE_HI     15
`define PIRC_IND_MODE_LO     14
`define PIRC_IND_MODE_RESET  2'h0
`define PIRC_IND_MODE_0      2'h0
`define PIRC_IND_MODE_1      2'h1
`define PIRC_IND_MODE_2      2'h2
`define PIRC_POL_BIT         13
`define PIRC_FEF_BIT         12
`define PIRC_MDI_BIT         11
`define PIRC_LOOP_BIT        7
`define PIRC_LOOP_RESET      1'b0
`define PIRC_VARIANT_BIT     15
`define PIRC_VARIANT_RESET   1'b1
`define PIRC_SWAP_BIT        14
`define PIRC_SWAP_RESET      1'b0
`define PIRC_XDIS_BIT        13
`define PIRC_XDIS_RESET      1'b0
`define PIRC_IRQ_LVL_BIT     9
`define PIRC_IRQ_LVL_RESET   1'b0
`define PIRC_IRQ_PIN_RESET   1'b1
`define PIRC_IND_RESET       4'h0
`define PIRC_RDATA_RESET     16'h0000
`endif

// ---- shared/pirc_pkg.sv ----
// types of the management register bank
package pirc_pkg;
  typedef enum logic [1:0] {
    pirc_diag_idle = 2'b01,
    pirc_diag_run  = 2'b10
  } pirc_diag_t;

  typedef struct packed {
    logic [7:0]  ev_enable;
    logic [7:0]  ev_status;
    pirc_diag_t  diag_state;
    logic [1:0]  diag_result;
    logic [8:0]  diag_count;
    logic [1:0]  ind_mode;
    logic        loopback;
    logic        variant;
    logic        swap;
    logic        xdis;
    logic        irq_level;
    logic        irq_pin;
    logic [3:0]  ind;
    logic [15:0] rdata;
  } pirc_state_t;
endpackage : pirc_pkg

// ---- rtl/pirc_regs.sv ----
// event, cable diagnostic, indicator and crossover management registers
// Behaviour
// RQ1: enable bits 15..8 for eight events are writable and reset to zero.
// RQ2: status bit 7 latches jabber events, read-only, self-clearing, resets zero.
// RQ3: status bit 6 latches receive errors, read-only, self-clearing.
// RQ4: status bit 5 latches page received, read-only, self-clearing.
// RQ5: status bit 4 latches parallel detect faults, read-only, self-clearing.
// RQ6: status bit 3 latches link partner acknowledge, read-only, self-clearing.
// RQ7: status bit 2 latches link down transitions, read-only, self-clearing.
// RQ8: status bit 1 latches remote faults, read-only, self-clearing.
// RQ9: status bit 0 latches link up transitions, read-only, self-clearing.
// RQ10: writing one to diag bit 15 starts test; bit clears at completion.
// RQ11: two-bit diag outcome: normal, open, short, failed; resets zero.
// RQ12: nine-bit read-only fault distance count, about 0.39 m each.
// RQ13: indicator mode 00: collision, full duplex, speed, link/activity.
// RQ14: mode 01: activity, duplex or collision, speed, link.
// RQ15: mode 10: activity, duplex, 100M link, 10M link; 11 reserved.
// RQ16: bit 13 reads one when receive polarity is reversed.
// RQ17: bit 12 reads zero when a far-end fault is detected.
// RQ18: bit 7 set enables remote analog loopback; reset clear.
// RQ19: bit 15 selects crossover variant, reset one.
// RQ20: bit 14 swaps pairs when automatic crossover is disabled.
// RQ21: bit 15 of event register enables jabber events.
// RQ22: interrupt output active high when bit 9 set, else active low.
// RQ23: bit 13 set disables automatic crossover; reset zero.
// RQ24: interrupt asserted while any status bit meets its enable.
// RQ25: reading event register clears status; concurrent events stay latched.
`timescale 1ns/1ps
`include "pirc_defs.svh"
module pirc_regs (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [7:0]  event_pulse,
  input  wire logic        diag_done,
  input  wire logic [1:0]  diag_result_in,
  input  wire logic [8:0]  diag_count_in,
  output logic             diag_active,
  input  wire logic        collision,
  input  wire logic        full_duplex,
  input  wire logic        speed_100,
  input  wire logic        link_up,
  input  wire logic        activity,
  input  wire logic        polarity_reversed,
  input  wire logic        far_end_fault,
  input  wire logic        mdi_state,
  output logic             indicator_out_0,
  output logic             indicator_out_1,
  output logic             indicator_out_2,
  output logic             indicator_out_3,
  output logic             remote_loopback,
  output logic             crossover_variant_select,
  output logic             auto_crossover_disable,
  output logic             pair_swap,
  output logic             irq_out
);
  pirc_pkg::pirc_state_t st_q;
  pirc_pkg::pirc_state_t st_d;
  logic                  pending;
  logic [15:0]           rd_mux;

  always_comb begin
    pending = |(st_q.ev_enable & st_q.ev_status);
    case (reg_addr)
      `PIRC_ADDR_EVENT: rd_mux = {st_q.ev_enable, st_q.ev_status};
      `PIRC_ADDR_DIAG: begin
        rd_mux = 16'h0000;
        rd_mux[`PIRC_DIAG_START_BIT] =
          (st_q.diag_state == pirc_pkg::pirc_diag_run);
        rd_mux[`PIRC_DIAG_RES_HI:`PIRC_DIAG_RES_LO] = st_q.diag_result;
        rd_mux[`PIRC_DIAG_CNT_HI:`PIRC_DIAG_CNT_LO] = st_q.diag_count;
      end
      `PIRC_ADDR_MISC: begin
        rd_mux = 16'h0000;
        rd_mux[`PIRC_IND_MODE_HI:`PIRC_IND_MODE_LO] = st_q.ind_mode;
        // RQ16 polarity flag
        rd_mux[`PIRC_POL_BIT] = polarity_reversed;
        // RQ17 inverted far-end fault
        rd_mux[`PIRC_FEF_BIT] = ~far_end_fault;
        rd_mux[`PIRC_MDI_BIT] = mdi_state;
        rd_mux[`PIRC_LOOP_BIT] = st_q.loopback;
      end
      `PIRC_ADDR_XOVER: begin
        rd_mux = 16'h0000;
        rd_mux[`PIRC_VARIANT_BIT] = st_q.variant;
        rd_mux[`PIRC_SWAP_BIT] = st_q.swap;
        rd_mux[`PIRC_XDIS_BIT] = st_q.xdis;
        rd_mux[`PIRC_IRQ_LVL_BIT] = st_q.irq_level;
      end
      default: rd_mux = 16'h0000;
    endcase
  end

  always_comb begin
    st_d = st_q;
    if (reg_rd) begin
      st_d.rdata = rd_mux;
    end
    // RQ25 clear on read
    if (reg_rd && reg_addr == `PIRC_ADDR_EVENT) begin
      st_d.ev_status = `PIRC_EV_RESET;
    end
    // RQ2 RQ3 RQ4 RQ5 RQ6 RQ7 RQ8 RQ9 event latching, set wins
    st_d.ev_status = st_d.ev_status | event_pulse;
    if (reg_wr) begin
      case (reg_addr)
        `PIRC_ADDR_EVENT: begin
          // RQ1 RQ21 enable bits
          st_d.ev_enable = reg_wdata[`PIRC_EV_ENA_HI:`PIRC_EV_ENA_LO];
        end
        `PIRC_ADDR_MISC: begin
          st_d.ind_mode = reg_wdata[`PIRC_IND_MODE_HI:`PIRC_IND_MODE_LO];
          // RQ18 loopback control
          st_d.loopback = reg_wdata[`PIRC_LOOP_BIT];
        end
        `PIRC_ADDR_XOVER: begin
          // RQ19 RQ20 RQ23 crossover controls
          st_d.variant = reg_wdata[`PIRC_VARIANT_BIT];
          st_d.swap = reg_wdata[`PIRC_SWAP_BIT];
          st_d.xdis = reg_wdata[`PIRC_XDIS_BIT];
          // RQ22 interrupt level
          st_d.irq_level = reg_wdata[`PIRC_IRQ_LVL_BIT];
        end
        default: begin
        end
      endcase
    end
    // RQ10 diagnostic sequencing
    case (st_q.diag_state)
      pirc_pkg::pirc_diag_idle: begin
        if (reg_wr && reg_addr == `PIRC_ADDR_DIAG &&
            reg_wdata[`PIRC_DIAG_START_BIT]) begin
          st_d.diag_state = pirc_pkg::pirc_diag_run;
        end
      end
      pirc_pkg::pirc_diag_run: begin
        if (diag_done) begin
          st_d.diag_state = pirc_pkg::pirc_diag_idle;
          // RQ11 RQ12 result capture
          st_d.diag_result = diag_result_in;
          st_d.diag_count = diag_count_in;
        end
      end
      default: st_d.diag_state = pirc_pkg::pirc_diag_idle;
    endcase
    // RQ24 interrupt pin
    st_d.irq_pin = st_q.irq_level ? pending : ~pending;
    case (st_q.ind_mode)
      // RQ13 mode 00
      `PIRC_IND_MODE_0: st_d.ind = {collision, full_duplex, speed_100,
                                    link_up | activity};
      // RQ14 mode 01
      `PIRC_IND_MODE_1: st_d.ind = {activity, full_duplex | collision,
                                    speed_100, link_up};
      // RQ15 mode 10
      `PIRC_IND_MODE_2: st_d.ind = {activity, full_duplex,
                                    link_up & speed_100,
                                    link_up & ~speed_100};
      default: st_d.ind = `PIRC_IND_RESET;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_q.ev_enable   <= `PIRC_EV_RESET;
      st_q.ev_status   <= `PIRC_EV_RESET;
      st_q.diag_state  <= pirc_pkg::pirc_diag_idle;
      st_q.diag_result <= `PIRC_DIAG_RES_RESET;
      st_q.diag_count  <= `PIRC_DIAG_CNT_RESET;
      st_q.ind_mode    <= `PIRC_IND_MODE_RESET;
      st_q.loopback    <= `PIRC_LOOP_RESET;
      st_q.variant     <= `PIRC_VARIANT_RESET;
      st_q.swap        <= `PIRC_SWAP_RESET;
      st_q.xdis        <= `PIRC_XDIS_RESET;
      st_q.irq_level   <= `PIRC_IRQ_LVL_RESET;
      st_q.irq_pin     <= `PIRC_IRQ_PIN_RESET;
      st_q.ind         <= `PIRC_IND_RESET;
      st_q.rdata       <= `PIRC_RDATA_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign diag_active = (st_q.diag_state == pirc_pkg::pirc_diag_run);
  assign indicator_out_0 = st_q.ind[0];
  assign indicator_out_1 = st_q.ind[1];
  assign indicator_out_2 = st_q.ind[2];
  assign indicator_out_3 = st_q.ind[3];
  assign remote_loopback = st_q.loopback;
  assign crossover_variant_select = st_q.variant;
  assign auto_crossover_disable = st_q.xdis;
  assign pair_swap = st_q.swap;
  assign irq_out = st_q.irq_pin;

  a_event_latch: // RQ9
    assert property (@(posedge clock) disable iff (srst)
      (event_pulse != 8'h00) |=>
        ((st_q.ev_status & $past(event_pulse)) == $past(event_pulse)))
    else $error("event not latched");

  a_read_clears: // RQ25
    assert property (@(posedge clock) disable iff (srst)
      (reg_rd && reg_addr == `PIRC_ADDR_EVENT && event_pulse == 8'h00)
        |=> (st_q.ev_status == 8'h00))
    else $error("status not cleared by read");

  a_enable_reset: // RQ1
    assert property (@(posedge clock)
      srst |=> (st_q.ev_enable == `PIRC_EV_RESET &&
                st_q.ev_status == `PIRC_EV_RESET))
    else $error("enables not zero after reset");

  a_irq_follow: // RQ24
    assert property (@(posedge clock) disable iff (srst)
      (|(st_q.ev_enable & st_q.ev_status)) |=>
        (irq_out == $past(st_q.irq_level)))
    else $error("interrupt not asserted");

  a_irq_idle: // RQ22
    assert property (@(posedge clock) disable iff (srst)
      (st_q.ev_status == 8'h00) |=> (irq_out == ~$past(st_q.irq_level)))
    else $error("interrupt idle level wrong");

  a_diag_hold: // RQ10
    assert property (@(posedge clock) disable iff (srst)
      (diag_active && !diag_done) |=> diag_active)
    else $error("diagnostic ended early");

  a_diag_result: // RQ11
    assert property (@(posedge clock) disable iff (srst)
      (diag_active && diag_done) |=> (!diag_active &&
        st_q.diag_result == $past(diag_result_in) &&
        st_q.diag_count == $past(diag_count_in)))
    else $error("diagnostic result not captured");

  a_led_mode0: // RQ13
    assert property (@(posedge clock) disable iff (srst)
      (st_q.ind_mode == `PIRC_IND_MODE_0 && !reg_wr) |=>
        (indicator_out_3 == $past(collision) &&
         indicator_out_2 == $past(full_duplex) &&
         indicator_out_1 == $past(speed_100)))
    else $error("indicator mode 0 mapping wrong");

  a_far_end_read: // RQ17
    assert property (@(posedge clock) disable iff (srst)
      (reg_rd && reg_addr == `PIRC_ADDR_MISC) |=>
        (reg_rdata[`PIRC_FEF_BIT] == ~$past(far_end_fault)))
    else $error("far-end fault sense wrong");

  a_loopback_ctl: // RQ18
    assert property (@(posedge clock) disable iff (srst)
      (reg_wr && reg_addr == `PIRC_ADDR_MISC) |=>
        (remote_loopback == $past(reg_wdata[`PIRC_LOOP_BIT])))
    else $error("loopback not written");

  a_enable_write: // RQ1
    assert property (@(posedge clock) disable iff (srst)
      (reg_wr && reg_addr == `PIRC_ADDR_EVENT) |=>
        (st_q.ev_enable ==
         $past(reg_wdata[`PIRC_EV_ENA_HI:`PIRC_EV_ENA_LO])))
    else $error("event enables not written");

  a_status_hold: // RQ2
    assert property (@(posedge clock) disable iff (srst)
      !(reg_rd && reg_addr == `PIRC_ADDR_EVENT) |=>
        ((st_q.ev_status & $past(st_q.ev_status)) ==
         $past(st_q.ev_status)))
    else $error("event status lost without read");

  a_diag_start: // RQ10
    assert property (@(posedge clock) disable iff (srst)
      (!diag_active && reg_wr && reg_addr == `PIRC_ADDR_DIAG &&
       reg_wdata[`PIRC_DIAG_START_BIT]) |=> diag_active)
    else $error("diagnostic did not start");

  a_diag_read: // RQ12
    assert property (@(posedge clock) disable iff (srst)
      (reg_rd && reg_addr == `PIRC_ADDR_DIAG) |=>
        (reg_rdata[`PIRC_DIAG_CNT_HI:`PIRC_DIAG_CNT_LO] ==
           $past(st_q.diag_count) &&
         reg_rdata[`PIRC_DIAG_START_BIT] == $past(diag_active)))
    else $error("diagnostic read data wrong");

  a_led_mode1: // RQ14
    assert property (@(posedge clock) disable iff (srst)
      (st_q.ind_mode == `PIRC_IND_MODE_1) |=>
        (indicator_out_3 == $past(activity) &&
         indicator_out_2 == ($past(full_duplex) | $past(collision)) &&
         indicator_out_1 == $past(speed_100) &&
         indicator_out_0 == $past(link_up)))
    else $error("indicator mode 1 mapping wrong");

  a_led_mode2: // RQ15
    assert property (@(posedge clock) disable iff (srst)
      (st_q.ind_mode == `PIRC_IND_MODE_2) |=>
        (indicator_out_3 == $past(activity) &&
         indicator_out_2 == $past(full_duplex) &&
         indicator_out_1 == ($past(link_up) & $past(speed_100)) &&
         indicator_out_0 == ($past(link_up) & ~$past(speed_100))))
    else $error("indicator mode 2 mapping wrong");

  a_polarity_read: // RQ16
    assert property (@(posedge clock) disable iff (srst)
      (reg_rd && reg_addr == `PIRC_ADDR_MISC) |=>
        (reg_rdata[`PIRC_POL_BIT] == $past(polarity_reversed)))
    else $error("polarity flag wrong");

  a_xover_ctl: // RQ23
    assert property (@(posedge clock) disable iff (srst)
      (reg_wr && reg_addr == `PIRC_ADDR_XOVER) |=>
        (auto_crossover_disable == $past(reg_wdata[`PIRC_XDIS_BIT]) &&
         pair_swap == $past(reg_wdata[`PIRC_SWAP_BIT]) &&
         crossover_variant_select ==
           $past(reg_wdata[`PIRC_VARIANT_BIT])))
    else $error("crossover controls not written");
endmodule : pirc_regs

// ---- test/pirc_host_model.sv ----
// host model driving the register strobe port
`timescale 1ns/1ps
`include "pirc_defs.svh"
module pirc_host_model (
  input  wire logic        clock,
  input  wire logic [15:0] reg_rdata,
  output logic      [4:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd
);
  initial begin
    reg_addr  = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // released bus shows inverted values
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clock);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clock);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask : rd
  task automatic wait_diag(output logic [15:0] d);
    d = 16'h8000;
    for (int i = 0; i < 20 && d[15] !== 1'b0; i++) begin
      rd(`PIRC_ADDR_DIAG, d);
    end
  endtask : wait_diag
endmodule : pirc_host_model

// ---- test/pirc_regs_tb.sv ----
// self-checking bench of the management register bank
`timescale 1ns/1ps
module pirc_regs_tb;
  logic        clock, srst, wr, rd, done, act, irq;
  logic        lpb, var_sel, xdis, swap;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, d;
  logic [7:0]  ev, st;
  logic [3:0]  ind;
  logic [1:0]  res;
  logic [8:0]  cnt;
  int          n_errors = 0;
  int          n_tests = 0;
  pirc_host_model i_pirc_host_model (.clock(clock), .reg_rdata(rdata),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));
  pirc_regs i_pirc_regs (.clock(clock), .srst(srst), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .event_pulse(ev), .diag_done(done), .diag_result_in(res),
    .diag_count_in(cnt), .diag_active(act), .collision(st[7]),
    .full_duplex(st[6]), .speed_100(st[5]), .link_up(st[4]),
    .activity(st[3]), .polarity_reversed(st[2]), .far_end_fault(st[1]),
    .mdi_state(st[0]), .indicator_out_0(ind[0]), .indicator_out_1(ind[1]),
    .indicator_out_2(ind[2]), .indicator_out_3(ind[3]),
    .remote_loopback(lpb), .crossover_variant_select(var_sel),
    .auto_crossover_disable(xdis), .pair_swap(swap), .irq_out(irq));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic conclude;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] v;
    i_pirc_host_model.rd(a, v);
    chk(v, exp);
  endtask : rchk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic pulse(input logic [7:0] p);
    tick(1);
    ev = p;
    tick(1);
    ev = 8'h00;
  endtask : pulse
  function automatic logic [3:0] ind_exp(input logic [1:0] m,
                                         input logic [7:0] s);
    logic c, f, sp, l, a;
    {c, f, sp, l, a} = s[7:3];
    case (m)
      2'h0: ind_exp = {c, f, sp, l | a};
      2'h1: ind_exp = {a, f | c, sp, l};
      2'h2: ind_exp = {a, f, l & sp, l & ~sp};
      default: ind_exp = 4'h0;
    endcase
  endfunction : ind_exp
  initial begin
    #100000;
    n_errors++;
    conclude();
  end
  initial begin
    srst = 1'b1;
    ev = 8'h00;
    done = 1'b0;
    res = 2'h0;
    cnt = 9'h000;
    st = 8'h00;
    tick(3);
    srst = 1'b0;
    rchk(5'h1b, 16'h0000);
    rchk(5'h1d, 16'h0000);
    rchk(5'h1f, 16'h8000);
    rchk(5'h00, 16'h0000);
    chk(16'({var_sel, xdis, swap, lpb, irq}), 16'h11);
    st = 8'h07;
    i_pirc_host_model.wr(5'h1e, 16'h1f80);
    rchk(5'h1e, 16'h2880);
    chk(16'(lpb), 16'h1);
    i_pirc_host_model.wr(5'h1f, 16'h6200);
    rchk(5'h1f, 16'h6200);
    chk(16'({var_sel, xdis, swap, irq}), 16'h6);
    i_pirc_host_model.wr(5'h1b, 16'hffff);
    rchk(5'h1b, 16'hff00);
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      tick(2);
      chk(16'(irq), 16'h1);
      rchk(5'h1b, 16'hff00 | (16'h1 << i));
      tick(2);
      chk(16'(irq), 16'h0);
    end
    i_pirc_host_model.wr(5'h1b, 16'h0000);
    pulse(8'hff);
    tick(2);
    chk(16'(irq), 16'h0);
    rchk(5'h1b, 16'h00ff);
    fork
      i_pirc_host_model.rd(5'h1b, d);
      pulse(8'h04);
    join
    chk(d, 16'h0000);
    rchk(5'h1b, 16'h0004);
    i_pirc_host_model.wr(5'h1f, 16'h8000);
    i_pirc_host_model.wr(5'h1b, 16'h0400);
    pulse(8'h04);
    tick(2);
    chk(16'(irq), 16'h0);
    rchk(5'h1b, 16'h0404);
    tick(2);
    chk(16'(irq), 16'h1);
    for (int r = 0; r < 4; r++) begin
      i_pirc_host_model.wr(5'h1d, 16'h8000);
      chk(16'(act), 16'h1);
      tick(1);
      done = 1'b1;
      res = 2'(r);
      cnt = (r == 3) ? 9'h1ff : 9'h0a5 + 9'(r);
      tick(1);
      done = 1'b0;
      res = ~res;
      cnt = ~cnt;
      i_pirc_host_model.wait_diag(d);
      chk(d, {1'b0, 2'(r), 4'h0, ~cnt});
      chk(16'(act), 16'h0);
    end
    for (int p = 0; p < 2; p++) begin
      st = p ? 8'h58 : 8'hb8;
      for (int m = 0; m < 4; m++) begin
        i_pirc_host_model.wr(5'h1e, {2'(m), 14'h0});
        rchk(5'h1e, {2'(m), 14'h1000});
        tick(2);
        chk(16'(ind), 16'(ind_exp(2'(m), st)));
      end
    end
    srst = 1'b1;
    tick(2);
    srst = 1'b0;
    rchk(5'h1b, 16'h0000);
    rchk(5'h1d, 16'h0000);
    chk(16'({var_sel, xdis, swap, lpb, irq}), 16'h11);
    conclude();
  end
endmodule : pirc_regs_tb
